// ==== hw/amh_cfg.svh ====
// Purpose: constants for the axis mode and handwheel feed block
// Assumes: 40 MHz clock, word-indexed register port
// Notes: offsets are register indexes on the plain register port
`ifndef AMH_CFG_SVH
`define AMH_CFG_SVH
`define AMH_ADDR_W 4
`define AMH_OFF_CMD 4'h0
`define AMH_OFF_MODE 4'h1
`define AMH_OFF_TARGET 4'h2
`define AMH_OFF_ENV2 4'h3
`define AMH_OFF_LSPD 4'h4
`define AMH_OFF_HSPD 4'h5
`define AMH_OFF_OFFSET 4'h6
`define AMH_OFF_ERR 4'h7
`define AMH_OFF_STAT 4'h8
`define AMH_OFF_REMAIN 4'h9
`define AMH_OFF_SPEED 4'ha
`define AMH_OFF_RAMP 4'hb
`define AMH_OFF_CALC 4'hc
`define AMH_CMD_START_LOW 8'h50
`define AMH_CMD_START_HIGH 8'h51
`define AMH_CMD_STOP 8'h49
`define AMH_MODE_CONT_POS 7'h00
`define AMH_MODE_CONT_NEG 7'h08
`define AMH_MODE_HW_CONT 7'h01
`define AMH_MODE_POSN 7'h41
`define AMH_MODE_TIMER 7'h47
`define AMH_MODE_HW_POSN 7'h51
`define AMH_MODE_OP_MSB 6
`define AMH_MODE_SETTLE_BIT 9
`define AMH_MODE_COMPLETION_TIMING_SELECT_BIT 12
`define AMH_MODE_MANSD_BIT 13
`define AMH_ENV2_DISABLE_BIT 15
`define AMH_ENV2_PIM_LSB 20
`define AMH_ENV2_SENSE_BIT 23
`define AMH_ENV2_FILTER_BIT 27
`define AMH_ERR_PHASE_BIT 8
`define AMH_ERR_OVF_BIT 6
`define AMH_ERR_PLIM_BIT 0
`define AMH_ERR_MLIM_BIT 1
`define AMH_ERR_ALM_BIT 2
`define AMH_ERR_STOP_BIT 3
`define AMH_ERR_EMG_BIT 4
`define AMH_STATE_IDLE 4'h0
`define AMH_STATE_WAIT_HW 4'h8
`define AMH_STATE_FEED_LOW 4'ha
`define AMH_STATE_FEED_HIGH 4'hc
`define AMH_STATE_WAIT_SETTLE 4'he
`define AMH_FILTER_MS 32
`define AMH_CLK_KHZ 40000
`define AMH_FILTER_CYC (`AMH_FILTER_MS * `AMH_CLK_KHZ)
`endif

// ==== hw/amh_pkg.sv ====
// Purpose: types for the axis mode and handwheel feed block
// Assumes: constants live in amh_cfg.svh
// Notes: none
package amh_pkg;
	typedef enum logic [2:0] {
		AMH_IDLE,
		AMH_RUN,
		AMH_HW_WAIT,
		AMH_SETTLE
	} amh_state_e;
	typedef logic [1:0] amh_pim_t;
endpackage : amh_pkg

// ==== hw/amh_axis.sv ====
// Purpose: one axis: mode select, command/positioning/timer feed, handwheel feed, readbacks
// Assumes: inputs synchronous to clk_i; speed ramp generated elsewhere
// Notes: register reads return data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "amh_cfg.svh"
// Operation
// [R1] speed readback bits 13:0, zero when stopped
// [R2] index pulse count in bits 19:16
// [R3] auto ramp point is calc plus offset
// [R4] manual ramp point equals programmed offset; code returns offset bits 22:0 with bit 23 cleared
// [R5] mode from bits 6:0 of prereg
// [R6] 00h positive, 08h negative continuous feed
// [R7] continuous feed stops on direction limit
// [R8] positioning direction from target sign
// [R9] counter loads abs target, stops at zero
// [R10] timer mode masks pulses, direction positive
// [R11] timer treats negative target as unsigned; code does so only when the previous start also latched timer
// [R12] timer ignores limits, slowdown, alarm
// [R13] timer skips direction timer and settle wait
// [R14] host clears completion timing bit in timer
// [R15] handwheel needs enable pin low, bit clear
// [R16] handwheel started by 50h or 51h only
// [R17] input method from bits 21:20
// [R18] count sense bit 23 swaps phase roles
// [R19] output pulses taken from internal train
// [R20] phase error bit 8, overflow bit 6
// [R21] run state 1000 waiting for handwheel
// [R22] filter ignores pulses under 32 ms
// [R23] error register cleared by read
// [R24] handwheel positioning ignores pulses at zero
module amh_axis
	import amh_pkg::*;
#(
	parameter int unsigned FILTER_CYC = `AMH_FILTER_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic low_tick_i,
	input wire logic high_tick_i,
	input wire logic [13:0] cur_speed_i,
	input wire logic index_i,
	input wire logic limit_pos_i,
	input wire logic limit_neg_i,
	input wire logic slowdown_i,
	input wire logic alarm_i,
	input wire logic stop_i,
	input wire logic emergency_i,
	input wire logic settle_done_i,
	input wire logic manual_enable_n_i,
	input wire logic phase_a_i,
	input wire logic phase_b_i,
	output logic step_o,
	output logic dir_o,
	output logic running_o
);
	// control registers
	logic [31:0] mode_reg;
	logic [31:0] target_reg;
	logic [31:0] env2_reg;
	logic [23:0] offset_reg;
	logic [23:0] calc_reg;
	logic [8:0] err_reg;
	logic [27:0] remain_reg;
	logic [3:0] index_cnt_reg;
	logic [3:0] buf_cnt_reg;
	logic buf_dir_reg;
	logic [6:0] op_reg;
	logic high_reg;
	logic [1:0] ab_reg;
	logic index_d_reg;
	logic pe_filt_reg;
	logic [31:0] filt_cnt_reg;
	logic slowdown_seen_reg;
	amh_state_e state_reg;

	// decoded strobes and modes
	logic start_cmd;
	logic stop_cmd;
	logic tick;
	logic timer_mode;
	logic hw_mode;
	logic lim_hit;
	logic hard_stop;
	logic hw_enabled;
	logic hw_step;
	logic hw_up;
	logic hw_err;
	logic do_pulse;
	logic pos_done;
	logic start_timer;
	logic step_ok;
	logic [27:0] abs_target;

	assign start_cmd = wr_i && addr_i == `AMH_OFF_CMD &&
		(wdata_i[7:0] == `AMH_CMD_START_LOW || wdata_i[7:0] == `AMH_CMD_START_HIGH);
	assign stop_cmd = wr_i && addr_i == `AMH_OFF_CMD && wdata_i[7:0] == `AMH_CMD_STOP;
	assign tick = high_reg ? high_tick_i : low_tick_i; // [R19]
	assign timer_mode = op_reg == `AMH_MODE_TIMER;
	assign hw_mode = op_reg == `AMH_MODE_HW_CONT || op_reg == `AMH_MODE_HW_POSN;
	// limits ignored in timer mode
	assign lim_hit = !timer_mode && (dir_o ? limit_pos_i : limit_neg_i); // [R7] [R12]
	// a timer start must not be refused by the alarm it is meant to ignore
	assign start_timer = mode_reg[`AMH_MODE_OP_MSB:0] == `AMH_MODE_TIMER;
	assign hard_stop = stop_i || emergency_i ||
		(!(start_cmd ? start_timer : timer_mode) && alarm_i); // [R12]
	assign hw_enabled = !pe_filt_reg && !env2_reg[`AMH_ENV2_DISABLE_BIT]; // [R15]
	// target taken unsigned when the previous start latched timer, others by magnitude
	assign abs_target = (target_reg[31] && op_reg != `AMH_MODE_TIMER) ?
		28'(-target_reg) : target_reg[27:0]; // [R9] [R11]
	assign pos_done = remain_reg == 28'h0;

	// quadrature and up/down decode
	function automatic logic [2:0] amh_decode(input logic [1:0] prev, input logic [1:0] cur,
		input amh_pim_t handwheel_input_method, input logic sense);
		logic a_lead;
		logic step;
		logic err;
		a_lead = 1'b0;
		step = 1'b0;
		// outside method 11, both phases moving at once is an error, never a step
		err = (prev[0] != cur[0]) && (prev[1] != cur[1]);
		if (handwheel_input_method == 2'b11) begin
			if (!prev[0] && cur[0]) begin
				step = 1'b1;
				a_lead = 1'b1;
			end else if (!prev[1] && cur[1]) begin
				step = 1'b1;
			end
		end else if (!err && prev != cur) begin
			a_lead = (prev[0] != cur[0]) ? (cur[0] != cur[1]) : (cur[0] == cur[1]);
			unique case (handwheel_input_method)
				2'b00: step = prev[0] != cur[0] && cur[0];
				2'b01: step = prev[0] != cur[0];
				default: step = 1'b1;
			endcase
			if (handwheel_input_method == 2'b00 && !a_lead)
				step = prev[0] != cur[0] && !cur[0];
		end
		amh_decode = {err, step, a_lead ^ sense}; // [R17] [R18]
	endfunction : amh_decode

	logic [2:0] dec;
	assign dec = amh_decode(ab_reg, {phase_b_i, phase_a_i},
		amh_pim_t'(env2_reg[`AMH_ENV2_PIM_LSB +: 2]), env2_reg[`AMH_ENV2_SENSE_BIT]);
	assign hw_err = dec[2] && env2_reg[`AMH_ENV2_PIM_LSB +: 2] != 2'b11;
	assign hw_step = dec[1] && hw_enabled && state_reg != AMH_IDLE && hw_mode;
	assign hw_up = dec[0];
	// a buffered handwheel step drains on an internal tick
	assign do_pulse = state_reg == AMH_RUN && tick && (!hw_mode || buf_cnt_reg != 4'h0);
	// handwheel continuous only drops the step that would run into a limit
	assign step_ok = do_pulse && !(op_reg == `AMH_MODE_HW_CONT && lim_hit); // [R7]

	// register writes
	// commands are not stored, only decoded as strobes
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg <= 32'h0;
			target_reg <= 32'h0;
			env2_reg <= 32'h0;
			offset_reg <= 24'h0;
			calc_reg <= 24'h0;
		end else if (wr_i) begin
			unique case (addr_i)
				`AMH_OFF_MODE: mode_reg <= wdata_i;
				`AMH_OFF_TARGET: target_reg <= wdata_i;
				`AMH_OFF_ENV2: env2_reg <= wdata_i;
				`AMH_OFF_OFFSET: offset_reg <= wdata_i[23:0];
				`AMH_OFF_CALC: calc_reg <= wdata_i[23:0];
				default: ;
			endcase
		end
	end

	// phase sampling, index edge, filter on enable pin
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ab_reg <= 2'b00;
			index_d_reg <= 1'b0;
			pe_filt_reg <= 1'b1;
			filt_cnt_reg <= 32'h0;
		end else begin
			ab_reg <= {phase_b_i, phase_a_i};
			index_d_reg <= index_i;
			// with the filter bit set, the pin is taken only after FILTER_CYC steady cycles
			if (!env2_reg[`AMH_ENV2_FILTER_BIT] || manual_enable_n_i == pe_filt_reg) begin
				filt_cnt_reg <= 32'h0;
				if (!env2_reg[`AMH_ENV2_FILTER_BIT])
					pe_filt_reg <= manual_enable_n_i;
			end else if (filt_cnt_reg >= 32'(FILTER_CYC - 1)) begin
				pe_filt_reg <= manual_enable_n_i; // [R22]
				filt_cnt_reg <= 32'h0;
			end else begin
				filt_cnt_reg <= filt_cnt_reg + 32'h1;
			end
		end
	end

	// index pulse count, cleared at start
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			index_cnt_reg <= 4'h0;
		else if (start_cmd)
			index_cnt_reg <= 4'h0;
		else if (index_i && !index_d_reg)
			index_cnt_reg <= index_cnt_reg + 4'h1; // [R2]
	end

	// axis state machine and remaining-pulse counter
	// a stop request beats a start in the same cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= AMH_IDLE;
			op_reg <= 7'h0;
			high_reg <= 1'b0;
			remain_reg <= 28'h0;
			dir_o <= 1'b1;
		end else if (stop_cmd || hard_stop) begin
			state_reg <= AMH_IDLE;
		end else if (start_cmd) begin
			op_reg <= mode_reg[`AMH_MODE_OP_MSB:0]; // [R5]
			high_reg <= wdata_i[7:0] == `AMH_CMD_START_HIGH;
			remain_reg <= abs_target; // [R9]
			// direction is latched at start and held for the move, except handwheel continuous, which follows its steps
			unique case (mode_reg[`AMH_MODE_OP_MSB:0])
				`AMH_MODE_CONT_POS: dir_o <= 1'b1; // [R6]
				`AMH_MODE_CONT_NEG: dir_o <= 1'b0; // [R6]
				`AMH_MODE_POSN, `AMH_MODE_HW_POSN: dir_o <= !target_reg[31]; // [R8]
				`AMH_MODE_TIMER: dir_o <= 1'b1; // [R10]
				default: ;
			endcase
			// a zero target in positioning, timer or handwheel positioning ends the start at once, no pulse leaves
			if (mode_reg[`AMH_MODE_OP_MSB:0] == `AMH_MODE_HW_CONT ||
				mode_reg[`AMH_MODE_OP_MSB:0] == `AMH_MODE_HW_POSN)
				state_reg <= (mode_reg[`AMH_MODE_OP_MSB:0] == `AMH_MODE_HW_POSN &&
					abs_target == 28'h0) ? AMH_IDLE : AMH_HW_WAIT; // [R16]
			else if ((mode_reg[`AMH_MODE_OP_MSB:0] == `AMH_MODE_POSN ||
				mode_reg[`AMH_MODE_OP_MSB:0] == `AMH_MODE_TIMER) && abs_target == 28'h0)
				state_reg <= AMH_IDLE; // [R9]
			else
				state_reg <= AMH_RUN;
		end else begin
			unique case (state_reg)
				AMH_IDLE: ;
				AMH_HW_WAIT: begin
					if (buf_cnt_reg != 4'h0)
						state_reg <= AMH_RUN;
				end
				AMH_RUN: begin
					// continuous handwheel follows the newest step's direction
					if (hw_mode && op_reg == `AMH_MODE_HW_CONT && buf_cnt_reg != 4'h0)
						dir_o <= buf_dir_reg;
					// every other mode except timer stops on the limit ahead of it
					if (lim_hit && op_reg != `AMH_MODE_HW_CONT) begin
						state_reg <= AMH_IDLE; // [R7]
					end else if (step_ok) begin
						if (op_reg != `AMH_MODE_CONT_POS && op_reg != `AMH_MODE_CONT_NEG &&
							op_reg != `AMH_MODE_HW_CONT) begin
							remain_reg <= remain_reg - 28'h1; // [R9]
							if (remain_reg == 28'h1)
								state_reg <= (mode_reg[`AMH_MODE_SETTLE_BIT] && !timer_mode) ?
									AMH_SETTLE : AMH_IDLE; // [R13]
						end
					end else if (hw_mode && buf_cnt_reg == 4'h0 && !pos_done) begin
						state_reg <= AMH_HW_WAIT;
					end
				end
				AMH_SETTLE: begin
					if (settle_done_i)
						state_reg <= AMH_IDLE;
				end
				default: state_reg <= AMH_IDLE;
			endcase
		end
	end

	// handwheel buffer counter with overflow
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			buf_cnt_reg <= 4'h0;
			buf_dir_reg <= 1'b1;
		end else if (start_cmd || state_reg == AMH_IDLE) begin
			buf_cnt_reg <= 4'h0;
		end else if (hw_step && !(op_reg == `AMH_MODE_HW_POSN && pos_done)) begin // [R24]
			// a step arriving while one drains leaves the count alone
			// the count saturates at 15 and the lost step is flagged
			if (!do_pulse && buf_cnt_reg != 4'hf)
				buf_cnt_reg <= buf_cnt_reg + 4'h1;
			if (op_reg == `AMH_MODE_HW_CONT)
				buf_dir_reg <= hw_up;
		end else if (do_pulse && hw_mode) begin
			buf_cnt_reg <= buf_cnt_reg - 4'h1;
		end
	end

	// outputs and slowdown tracking
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			step_o <= 1'b0;
			running_o <= 1'b0;
			slowdown_seen_reg <= 1'b0;
		end else begin
			// timer mode keeps counting, only the pin stays quiet
			step_o <= step_ok && !timer_mode; // [R10]
			running_o <= state_reg != AMH_IDLE;
			slowdown_seen_reg <= slowdown_i && !timer_mode; // [R12]
		end
	end

	// error flags, set wins over clear on read
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_reg <= 9'h0;
		end else begin
			// each cause flag stays set until the register is read
			err_reg <= (rd_i && addr_i == `AMH_OFF_ERR) ? 9'h0 : err_reg; // [R23]
			if (hw_err && hw_mode && state_reg != AMH_IDLE)
				err_reg[`AMH_ERR_PHASE_BIT] <= 1'b1; // [R20]
			if (hw_step && buf_cnt_reg == 4'hf && !do_pulse)
				err_reg[`AMH_ERR_OVF_BIT] <= 1'b1; // [R20]
			if (state_reg == AMH_RUN && lim_hit && dir_o && op_reg != `AMH_MODE_HW_CONT)
				err_reg[`AMH_ERR_PLIM_BIT] <= 1'b1;
			if (state_reg == AMH_RUN && lim_hit && !dir_o && op_reg != `AMH_MODE_HW_CONT)
				err_reg[`AMH_ERR_MLIM_BIT] <= 1'b1;
			if (state_reg != AMH_IDLE && alarm_i && !timer_mode)
				err_reg[`AMH_ERR_ALM_BIT] <= 1'b1;
			if (state_reg != AMH_IDLE && stop_i)
				err_reg[`AMH_ERR_STOP_BIT] <= 1'b1;
			if (state_reg != AMH_IDLE && emergency_i)
				err_reg[`AMH_ERR_EMG_BIT] <= 1'b1;
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 32'h0;
		end else if (rd_i) begin
			unique case (addr_i)
				`AMH_OFF_MODE: rdata_o <= mode_reg;
				`AMH_OFF_TARGET: rdata_o <= target_reg;
				`AMH_OFF_ENV2: rdata_o <= env2_reg;
				`AMH_OFF_ERR: rdata_o <= {23'h0, err_reg};
				// run state code with direction and slowdown beside it
				`AMH_OFF_STAT: rdata_o <= {26'h0, slowdown_seen_reg, !dir_o,
					state_reg == AMH_HW_WAIT ? `AMH_STATE_WAIT_HW : // [R21]
					state_reg == AMH_SETTLE ? `AMH_STATE_WAIT_SETTLE :
					state_reg == AMH_RUN ? (high_reg ? `AMH_STATE_FEED_HIGH :
					`AMH_STATE_FEED_LOW) : `AMH_STATE_IDLE};
				`AMH_OFF_REMAIN: rdata_o <= {4'h0, remain_reg};
				// speed reads zero while the axis is idle
				`AMH_OFF_SPEED: rdata_o <= {12'h0, index_cnt_reg, 2'b00,
					state_reg == AMH_IDLE ? 14'h0 : cur_speed_i}; // [R1] [R2]
				`AMH_OFF_RAMP: begin
					// manual point is the offset alone and never negative
					if (mode_reg[`AMH_MODE_MANSD_BIT])
						rdata_o <= {9'h0, offset_reg[22:0]}; // [R4]
					else
						rdata_o <= {8'h00, 24'(calc_reg + offset_reg)}; // [R3]
				end
				default: rdata_o <= 32'h0;
			endcase
		end else begin
			rdata_o <= 32'h0;
		end
	end
endmodule : amh_axis
`default_nettype wire

// ==== test/amh_axis_properties.sv ====
// Purpose: port checks for the axis block
// Assumes: register indexes 0 cmd, 1 mode, 2 target, a speed
// Notes: mode and zero target tracked from host writes
`timescale 1ns/1ps
`default_nettype none
module amh_axis_properties (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic low_tick_i,
	input wire logic high_tick_i,
	input wire logic limit_pos_i,
	input wire logic stop_i,
	input wire logic step_o,
	input wire logic dir_o,
	input wire logic running_o
);
	logic [6:0] mode_reg;
	logic zero_reg;
	logic start_w;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// either start code on the command index
	assign start_w = wr_i && addr_i == 4'h0 && wdata_i[7:1] == 7'h28;
	// last mode and whether the target is zero
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg <= 7'h00;
			zero_reg <= 1'b0;
		end else if (wr_i && addr_i == 4'h1) begin
			mode_reg <= wdata_i[6:0];
		end else if (wr_i && addr_i == 4'h2) begin
			zero_reg <= wdata_i == 32'h0;
		end
	end
	spd_upper_a:
		assert property (rd_i && addr_i == 4'ha |=> rdata_o[31:20] == 12'h0 && rdata_o[15:14] == 2'h0)
		else $error("speed upper bits set");
	spd_idle_a:
		assert property (rd_i && addr_i == 4'ha && !running_o |=> rdata_o[13:0] == 14'h0)
		else $error("speed nonzero when stopped");
	step_tick_a:
		assert property (step_o |-> $past(low_tick_i) || $past(high_tick_i))
		else $error("step without tick");
	timer_mask_a:
		assert property (running_o && $past(running_o) && mode_reg == 7'h47 |-> !step_o && dir_o)
		else $error("timer output not masked");
	cont_limit_a:
		assert property (running_o && mode_reg == 7'h00 && limit_pos_i |-> ##[1:4] !running_o)
		else $error("limit did not stop");
	stop_cmd_a:
		assert property (wr_i && addr_i == 4'h0 && wdata_i[7:0] == 8'h49 |-> ##[1:4] !running_o)
		else $error("stop command ignored");
	stop_line_a:
		assert property (running_o && stop_i |-> ##[1:4] !running_o)
		else $error("stop line ignored");
	zero_target_a:
		assert property (start_w && mode_reg == 7'h41 && zero_reg |=> !step_o [*6])
		else $error("zero target stepped");
	cover property (start_w && mode_reg == 7'h47);
	cover property (running_o && limit_pos_i);
	cover property (rd_i && addr_i == 4'h7);
endmodule : amh_axis_properties
bind amh_axis amh_axis_properties u_props (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .low_tick_i, .high_tick_i, .limit_pos_i, .stop_i, .step_o, .dir_o, .running_o);
`default_nettype wire

// ==== test/amh_far_side.sv ====
// Purpose: far side: internal tick trains and motor driver step count
// Assumes: ticks are one-cycle pulses
// Notes: low train every 4 cycles, high train every 2
`timescale 1ns/1ps
`default_nettype none
module amh_far_side (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic step_i,
	output logic low_tick_o,
	output logic high_tick_o,
	output logic [31:0] step_count_o
);
	logic [1:0] div_reg;
	// free divider and step counter of the driver
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_reg <= 2'h0;
			step_count_o <= 32'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
			step_count_o <= step_count_o + 32'(step_i); // every pulse moves the motor
		end
	end
	assign low_tick_o = div_reg == 2'h3;
	assign high_tick_o = div_reg[0];
endmodule : amh_far_side
`default_nettype wire

// ==== test/axis_mode_and_handwheel_feed_bench.sv ====
// Purpose: scenario bench for the axis block
// Assumes: 40 MHz clock, register data one cycle after read
// Notes: filter shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module axis_mode_and_handwheel_feed_bench;
	logic clk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, index_i = 1'b0;
	logic limit_pos_i = 1'b0, limit_neg_i = 1'b0, slowdown_i = 1'b0, alarm_i = 1'b0;
	logic stop_i = 1'b0, man_n = 1'b0;
	logic phase_a_i = 1'b0, phase_b_i = 1'b0, step_o, dir_o, running_o, lo_t, hi_t;
	logic [3:0] addr_i = 4'h0;
	logic [13:0] cur_speed_i = 14'h1abc;
	logic [31:0] wdata_i = 32'h0, rdata_o, steps, base;
	int mismatches = 0, cmp_count = 0, cyc = 0;
	amh_axis #(.FILTER_CYC(8)) DUT (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.low_tick_i(lo_t), .high_tick_i(hi_t), .cur_speed_i, .index_i, .limit_pos_i,
		.limit_neg_i, .slowdown_i, .alarm_i, .stop_i, .emergency_i(1'b0),
		.settle_done_i(1'b0), .manual_enable_n_i(man_n), .phase_a_i, .phase_b_i, .step_o,
		.dir_o, .running_o);
	amh_far_side u_far (.clk_i, .arst_n_i, .step_i(step_o), .low_tick_o(lo_t),
		.high_tick_o(hi_t), .step_count_o(steps));
	// clock and hang guard
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, string w);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(w, e, rdata_o & m);
		@(posedge clk_i);
	endtask : rd
	task automatic idle(input int lim);
		@(posedge clk_i);
		for (int n = 0; n < lim && running_o !== 1'b0; n++) @(posedge clk_i);
		chk("running", 32'h0, 32'(running_o));
	endtask : idle
	task automatic ph(input logic a, input logic b);
		phase_a_i <= a;
		phase_b_i <= b;
		repeat (12) @(posedge clk_i);
	endtask : ph
	task automatic quad();
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b1);
		ph(1'b0, 1'b0);
	endtask : quad
	task automatic t_read();
		repeat (3) begin
			index_i <= 1'b1;
			@(posedge clk_i);
			index_i <= 1'b0;
			@(posedge clk_i);
		end
		rd(4'ha, 32'hffffffff, 32'h30000, "index speed");
		rd(4'hd, 32'hffffffff, 32'h0, "unmapped");
		wr(4'hc, 32'h10);
		wr(4'h6, 32'h5);
		wr(4'h1, 32'h0);
		rd(4'hb, 32'hffffffff, 32'h15, "auto ramp");
		wr(4'h1, 32'h2000);
		rd(4'hb, 32'hffffffff, 32'h5, "manual ramp");
	endtask : t_read
	task automatic t_posn();
		int t[3] = '{5, -3, 0};
		wr(4'h1, 32'h41);
		foreach (t[i]) begin
			wr(4'h2, 32'(t[i]));
			base = steps;
			wr(4'h0, 32'h50);
			if (t[i] != 0) chk("posn dir", 32'(t[i] > 0), 32'(dir_o));
			idle(400);
			chk("posn steps", 32'(t[i] < 0 ? -t[i] : t[i]), steps - base);
			rd(4'h9, 32'hffffffff, 32'h0, "remaining");
		end
	endtask : t_posn
	task automatic t_timer();
		wr(4'h1, 32'h247);
		wr(4'h2, 32'h6);
		{limit_pos_i, alarm_i, slowdown_i} <= 3'h7;
		base = steps;
		wr(4'h0, 32'h51);
		@(posedge clk_i);
		chk("timer run", 32'h1, 32'(running_o));
		rd(4'h8, 32'h3f, 32'hc, "timer status");
		idle(400);
		chk("timer steps", 32'h0, steps - base);
		wr(4'h2, 32'h64);
		wr(4'h0, 32'h51);
		stop_i <= 1'b1;
		idle(8);
		{limit_pos_i, alarm_i, slowdown_i, stop_i} <= 4'h0;
	endtask : t_timer
	task automatic t_cont();
		wr(4'h1, 32'h0);
		wr(4'h0, 32'h50);
		repeat (20) @(posedge clk_i);
		chk("cont run", 32'h3, {30'h0, running_o, dir_o});
		rd(4'ha, 32'h3fff, 32'h1abc, "speed");
		limit_pos_i <= 1'b1;
		idle(8);
		limit_pos_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("no restart", 32'h0, 32'(running_o));
		wr(4'h1, 32'h8);
		wr(4'h0, 32'h50);
		@(posedge clk_i);
		chk("neg run", 32'h2, {30'h0, running_o, dir_o});
		limit_pos_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("other limit", 32'h1, 32'(running_o));
		{limit_pos_i, limit_neg_i} <= 2'b01;
		idle(8);
		limit_neg_i <= 1'b0;
		wr(4'h0, 32'h50);
		@(posedge clk_i);
		chk("restart", 32'h1, 32'(running_o));
		wr(4'h0, 32'h49);
		idle(8);
	endtask : t_cont
	task automatic t_hand();
		logic [31:0] n[4] = '{32'h1, 32'h2, 32'h4, 32'h2};
		wr(4'h1, 32'h1);
		wr(4'h0, 32'h50);
		rd(4'h8, 32'hf, 32'h8, "wait state");
		for (int m = 0; m < 4; m++) begin
			wr(4'h3, 32'(m) << 20);
			base = steps;
			quad();
			chk("hw steps", n[m], steps - base);
		end
		wr(4'h3, 32'h800000);
		base = steps;
		quad();
		chk("sense", 32'h2, {steps[30:0] - base[30:0], dir_o});
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b0);
		rd(4'h7, 32'h100, 32'h100, "phase err");
		rd(4'h7, 32'hffffffff, 32'h0, "err cleared");
		wr(4'h3, 32'h8000);
		base = steps;
		quad();
		man_n <= 1'b1;
		wr(4'h3, 32'h0);
		quad();
		chk("hw disabled", 32'h0, steps - base);
		wr(4'h3, 32'h8000000);
		man_n <= 1'b0;
		repeat (3) @(posedge clk_i);
		man_n <= 1'b1;
		quad();
		chk("short enable", 32'h0, steps - base);
		man_n <= 1'b0;
		repeat (12) @(posedge clk_i);
		quad();
		chk("filtered enable", 32'h1, steps - base);
		wr(4'h1, 32'h51);
		wr(4'h2, 32'h2);
		wr(4'h3, 32'h200000);
		base = steps;
		wr(4'h0, 32'h50);
		quad();
		chk("hw posn steps", 32'h2, steps - base);
		chk("hw posn end", 32'h0, 32'(running_o));
		wr(4'h0, 32'h49);
		idle(8);
	endtask : t_hand
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	// reset, then each scenario in turn
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		t_read();
		t_posn();
		t_timer();
		t_cont();
		t_hand();
		complete_run();
	end
endmodule : axis_mode_and_handwheel_feed_bench
`default_nettype wire
